// File: verilog/cbms_pkg.sv
// cbms_pkg: constants and carrier types for the card bus mode front end
// assumes: shared by the top module and its byte assembler leaf module
//
// What this block does
// - mode is decided when the reset command arrives; later traffic follows it
// - only the first reset command after power-up picks the mode
// - native mode starts with data line zero only
// - bus-width command after initialization changes active data lines
// - upper data lines stay inputs until the bus-width command is accepted
// - detect/data-three pull-up is enabled at power-up
// - detect line low at reset command selects serial mode, else native
// - detect pull-up command disconnects the pull-up
// - serial tokens are whole bytes aligned to chip-select
// - serial card answers only while chip-select is low
// - serial mode has no broadcast commands
// - programming continues when chip-select is released
// - serial mode accepts the native command set less the broadcast commands
// - native card, once initialized, acts only on commands carrying its own address
// - native command and data lines two-way; clock host to card only
// - serial mode card drives only the output data line
package cbms_pkg;

  // ---------------------------------------------------------------------
  // command codes and widths
  // ---------------------------------------------------------------------
  localparam logic [5:0] CBMS_CMD_GO_IDLE      = 6'h00;
  localparam logic [5:0] CBMS_CMD_SELECT       = 6'h07;
  localparam logic [5:0] CBMS_CMD_APP          = 6'h37;
  localparam logic [5:0] CBMS_CMD_BUS_WIDTH    = 6'h06;
  localparam logic [5:0] CBMS_CMD_DETECT_PULL  = 6'h2a;
  localparam int         CBMS_BYTE_BITS        = 8;
  localparam logic [2:0] CBMS_BIT_LAST         = 3'h7;
  localparam logic [1:0] CBMS_WIDTH_FOUR       = 2'h2;
  localparam logic [15:0] CBMS_ADDR_RESET      = 16'h0000;
  localparam logic [3:0] CBMS_BROADCAST_LIMIT  = 4'h3;

  // ---------------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    CBMS_MODE_UNSET  = 3'b001,
    CBMS_MODE_NATIVE = 3'b010,
    CBMS_MODE_SERIAL = 3'b100
  } cbms_mode_type;

  // decoded command as handed over from the command decoder
  typedef struct packed {
    logic        valid;
    logic [5:0]  index;
    logic        app;
    logic [31:0] arg;
  } cbms_cmd_type;

  // pad drive set: output value and output enable per pad
  typedef struct packed {
    logic [3:0] dat_out;
    logic [3:0] dat_oe;
    logic       pull_en;
  } cbms_pads_type;

endpackage : cbms_pkg

// File: verilog/cbms_sync.sv
// cbms_sync: two flip-flop level synchroniser
// assumes: input is asynchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
module cbms_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  // first stage only feeds the second
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end

  assign q_o = s2_q;
endmodule : cbms_sync
`default_nettype wire

// File: verilog/cbms_byte_rx.sv
// cbms_byte_rx: serial byte assembler on the link clock
// assumes: the host frames bytes with chip-select; link clocks while it is high leave the counter cleared
`timescale 1ns/100ps
`default_nettype none
module cbms_byte_rx
  import cbms_pkg::*;
(
  // link clock, power-on reset and frame
  input  wire logic       link_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       frame_n_i,
  input  wire logic       din_i,
  // assembled byte, toggle marks a new one
  output logic [7:0]      byte_o,
  output logic            tog_o
);
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] byte_q, byte_d;
  logic       tog_q, tog_d;

  // bit counter restarts with each frame, so bytes align to its start
  always_comb begin
    cnt_d  = cnt_q + 3'h1;
    sh_d   = {sh_q[6:0], din_i};
    byte_d = byte_q;
    tog_d  = tog_q;
    if (cnt_q == CBMS_BIT_LAST) begin
      byte_d = {sh_q[6:0], din_i};
      tog_d  = ~tog_q;
    end
  end

  // frame end clears the counter asynchronously; no edge after it is needed
  always_ff @(posedge link_clk_i or posedge frame_n_i) begin
    if (frame_n_i) begin
      cnt_q <= '0;
      sh_q  <= '0;
    end else begin
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
    end
  end

  // byte and toggle survive frame end for the crossing; power-on reset
  // clears them so the core side's copy of the toggle starts equal
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      byte_q <= 8'h00;
      tog_q  <= 1'b0;
    end else begin
      byte_q <= byte_d;
      tog_q  <= tog_d;
    end
  end

  assign byte_o = byte_q;
  assign tog_o  = tog_q;
endmodule : cbms_byte_rx
`default_nettype wire

// File: verilog/cbms_front_end.sv
// cbms_front_end: picks native or serial protocol and steers the pads
// assumes: a command decoder on ref_clk_i hands over decoded commands;
// the serial link clock is the host clock on its own port
`timescale 1ns/100ps
`default_nettype none
module cbms_front_end
  import cbms_pkg::*;
(
  // clock and power-on reset
  input  wire logic          ref_clk_i,
  input  wire logic          resetn_i,
  // link clock from host
  input  wire logic          link_clk_i,
  // pads
  input  wire logic          detect_or_data3_line_i,
  input  wire logic          host_to_card_serial_i,
  // decoded commands from the command decoder
  input  wire cbms_cmd_type  cmd_i,
  input  wire logic          init_done_i,
  input  wire logic [15:0]   own_addr_i,
  input  wire logic          programming_i,
  // native data to drive
  input  wire logic [3:0]    native_dat_i,
  input  wire logic          native_dat_en_i,
  input  wire logic          card_to_host_serial_d_i,
  // pad drive and status
  output cbms_pads_type      pads_o,
  output cbms_mode_type      mode_o,
  output logic               cmd_accept_o,
  output logic               width_four_o,
  output logic               frame_active_o,
  output logic [7:0]         rx_byte_o,
  output logic               rx_byte_valid_o,
  output logic               program_hold_o
);

  // every check below runs on the core clock and sleeps through reset
  default clocking core_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  logic detect_s, frame_n_s, tog_s;
  logic [7:0] link_byte;
  logic       link_tog;

  cbms_sync #(.W(3)) u_sync (
    .clk_i    (ref_clk_i),
    .resetn_i (resetn_i),
    .d_i      ({detect_or_data3_line_i, detect_or_data3_line_i, link_tog}),
    .q_o      ({detect_s, frame_n_s, tog_s})
  );

  // ---------------------------------------------------------------------
  // serial byte capture on link clock
  // ---------------------------------------------------------------------
  cbms_byte_rx u_rx (
    .link_clk_i (link_clk_i),
    .resetn_i   (resetn_i),
    .frame_n_i  (detect_or_data3_line_i),
    .din_i      (host_to_card_serial_i),
    .byte_o     (link_byte),
    .tog_o      (link_tog)
  );

  // ---------------------------------------------------------------------
  // mode and configuration state
  // ---------------------------------------------------------------------
  cbms_mode_type mode_q, mode_d;
  logic          wide_q, wide_d;
  logic          pull_q, pull_d;
  logic          acc_q, acc_d;
  logic          tog_q, tog_d;
  logic          rxv_q, rxv_d;
  logic [7:0]    rxb_q, rxb_d;
  logic          hold_q, hold_d;
  cbms_pads_type pads_q, pads_d;
  logic          frame_q, frame_d;
  logic          addr_ok;
  logic          is_reset;
  logic          broadcast;

  assign is_reset = cmd_i.valid && !cmd_i.app &&
                    cmd_i.index == CBMS_CMD_GO_IDLE;
  // broadcast indices are the low ones other than the reset command
  assign broadcast = cmd_i.index <= {2'h0, CBMS_BROADCAST_LIMIT} &&
                     !is_reset;
  // own address check only once initialization is over
  assign addr_ok = !init_done_i || cmd_i.arg[31:16] == own_addr_i;

  // next-state for mode, width, pull-up and acceptance
  always_comb begin
    mode_d = mode_q;
    wide_d = wide_q;
    pull_d = pull_q;
    acc_d  = 1'b0;
    tog_d  = tog_s;
    rxv_d  = 1'b0;
    rxb_d  = rxb_q;
    frame_d = 1'b0;
    hold_d = hold_q;
    // first reset command fixes the mode until power goes away
    if (is_reset && mode_q == CBMS_MODE_UNSET) begin
      mode_d = detect_s ? CBMS_MODE_NATIVE : CBMS_MODE_SERIAL;
    end
    // serial gates by frame and drops broadcast indices; native by address
    if (cmd_i.valid && !is_reset) begin
      unique case (mode_q)
        CBMS_MODE_NATIVE: acc_d = addr_ok;
        CBMS_MODE_SERIAL: acc_d = !frame_n_s && !broadcast;
        default:          acc_d = 1'b0;
      endcase
    end
    if (acc_d && cmd_i.app && cmd_i.index == CBMS_CMD_BUS_WIDTH &&
        init_done_i && mode_q == CBMS_MODE_NATIVE) begin
      wide_d = cmd_i.arg[1:0] == CBMS_WIDTH_FOUR;
    end
    if (acc_d && cmd_i.app && cmd_i.index == CBMS_CMD_DETECT_PULL) begin
      pull_d = cmd_i.arg[0];
    end
    // programming carries on with chip-select released
    hold_d = programming_i;
    frame_d = mode_q == CBMS_MODE_SERIAL && !frame_n_s;
    if (tog_s != tog_q && mode_q == CBMS_MODE_SERIAL) begin
      rxv_d = 1'b1;
      rxb_d = link_byte; // stable: it changed before the toggle crossed
    end
  end

  // pad drive per mode
  always_comb begin
    pads_d = '0;
    pads_d.pull_en = pull_d;
    unique case (mode_d)
      CBMS_MODE_NATIVE: begin
        // line zero only until widened; upper lines stay inputs
        pads_d.dat_out    = native_dat_i;
        pads_d.dat_oe[0]  = native_dat_en_i;
        pads_d.dat_oe[3:1] = {3{native_dat_en_i && wide_d}};
      end
      CBMS_MODE_SERIAL: begin
        // only the output line; reserved pads float
        pads_d.dat_out[0] = card_to_host_serial_d_i;
        pads_d.dat_oe[0]  = !frame_n_s;
        pads_d.dat_oe[3:1] = 3'h0;
      end
      default: pads_d.dat_oe = 4'h0;
    endcase
  end

  // registers; pull-up is on from power-up
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_q  <= CBMS_MODE_UNSET;
      wide_q  <= 1'b0;
      pull_q  <= 1'b1;
      acc_q   <= 1'b0;
      tog_q   <= 1'b0;
      rxv_q   <= 1'b0;
      rxb_q   <= 8'h00;
      hold_q  <= 1'b0;
      frame_q <= 1'b0;
      pads_q  <= '{dat_out: 4'h0, dat_oe: 4'h0, pull_en: 1'b1};
    end else begin
      mode_q  <= mode_d;
      wide_q  <= wide_d;
      pull_q  <= pull_d;
      acc_q   <= acc_d;
      tog_q   <= tog_d;
      rxv_q   <= rxv_d;
      rxb_q   <= rxb_d;
      hold_q  <= hold_d;
      frame_q <= frame_d;
      pads_q  <= pads_d;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  assign pads_o          = pads_q;
  assign mode_o          = mode_q;
  assign cmd_accept_o    = acc_q;
  assign width_four_o    = wide_q;
  assign frame_active_o  = frame_q;
  assign rx_byte_o       = rxb_q;
  assign rx_byte_valid_o = rxv_q;
  assign program_hold_o  = hold_q;

  // ---------------------------------------------------------------------
  // checks: protocol choice
  // ---------------------------------------------------------------------
  // the choice is made once; a later reset command must leave it alone
  a_mode_sticky: assert property (
    mode_q != CBMS_MODE_UNSET |=> mode_q == $past(mode_q))
    else $error("mode changed after being fixed");

  a_mode_pick: assert property (
    is_reset && mode_q == CBMS_MODE_UNSET |=>
      mode_q == ($past(detect_s) ? CBMS_MODE_NATIVE : CBMS_MODE_SERIAL))
    else $error("reset command picked wrong mode");

  a_reset_quiet: assert property (
    is_reset |=> !acc_q)
    else $error("reset command was acknowledged");

  // ---------------------------------------------------------------------
  // checks: native bus lines
  // ---------------------------------------------------------------------
  // upper lines must never fight a host that still holds them as inputs;
  // widening is only legal once initialization is over
  a_upper_in: assert property (
    !wide_q |-> pads_q.dat_oe[3:1] == 3'h0)
    else $error("upper lines driven before widening");

  a_width_set: assert property (
    mode_q == CBMS_MODE_NATIVE && init_done_i && cmd_i.valid &&
    cmd_i.app && cmd_i.index == CBMS_CMD_BUS_WIDTH &&
    cmd_i.arg[31:16] == own_addr_i &&
    cmd_i.arg[1:0] == CBMS_WIDTH_FOUR |=> wide_q)
    else $error("bus width command did not widen");

  a_width_native: assert property (
    mode_q != CBMS_MODE_NATIVE |=> $stable(wide_q))
    else $error("width changed outside native mode");

  a_width_init: assert property (
    !init_done_i |=> $stable(wide_q))
    else $error("width changed before initialization");

  a_native_en: assert property (
    mode_q == CBMS_MODE_NATIVE |=>
      pads_q.dat_oe[0] == $past(native_dat_en_i))
    else $error("line zero drive does not follow enable");

  a_addr_match: assert property (
    mode_q == CBMS_MODE_NATIVE && cmd_i.valid && init_done_i &&
    cmd_i.arg[31:16] != own_addr_i |=> !acc_q)
    else $error("accepted command for another card");

  // ---------------------------------------------------------------------
  // checks: pull-up and programming
  // ---------------------------------------------------------------------
  // the pull-up is the only way a host can see the card before it talks,
  // so only the explicit command may touch it
  a_pull_boot: assert property (
    mode_q == CBMS_MODE_UNSET |-> pads_q.pull_en)
    else $error("pull-up off before mode set");

  a_pull_clear: assert property (
    acc_d && cmd_i.app && cmd_i.index == CBMS_CMD_DETECT_PULL &&
    !cmd_i.arg[0] |=> !pads_q.pull_en)
    else $error("pull-up not released");

  a_pull_keep: assert property (
    !(cmd_i.valid && cmd_i.app && cmd_i.index == CBMS_CMD_DETECT_PULL)
    |=> $stable(pull_q))
    else $error("pull-up changed without its command");

  a_prog_hold: assert property (
    programming_i |=> program_hold_o)
    else $error("programming dropped");

  a_hold_drop: assert property (
    !programming_i |=> !program_hold_o)
    else $error("programming hold stuck");

  // ---------------------------------------------------------------------
  // checks: serial link
  // ---------------------------------------------------------------------
  // chip-select gates both the answer and the output driver
  a_serial_rsv: assert property (
    mode_q == CBMS_MODE_SERIAL |=> pads_q.dat_oe[3:1] == 3'h0)
    else $error("reserved pads driven in serial mode");

  a_serial_out: assert property (
    mode_q == CBMS_MODE_SERIAL |=> pads_q.dat_out[3:1] == 3'h0)
    else $error("unused pad data set in serial mode");

  a_cs_accept: assert property (
    mode_q == CBMS_MODE_SERIAL && frame_n_s ##1 acc_q |-> 1'b0)
    else $error("accepted command without chip-select");

  a_cs_drive: assert property (
    mode_q == CBMS_MODE_SERIAL && frame_n_s |=> !pads_q.dat_oe[0])
    else $error("output line driven without chip-select");

  a_frame_flag: assert property (
    mode_q == CBMS_MODE_SERIAL && !frame_n_s |=> frame_active_o)
    else $error("frame flag missing while selected");

  a_no_bcast: assert property (
    mode_q == CBMS_MODE_SERIAL && cmd_i.valid && broadcast |=> !acc_q)
    else $error("broadcast command accepted in serial mode");

  a_rx_native: assert property (
    mode_q != CBMS_MODE_SERIAL |=> !rx_byte_valid_o)
    else $error("byte reported outside serial mode");

  a_rx_single: assert property (
    rx_byte_valid_o |=> !rx_byte_valid_o)
    else $error("byte pulse longer than one cycle");

endmodule : cbms_front_end
`default_nettype wire

// File: tb/cbms_host_model.sv
// cbms_host_model: host end of the serial link toward the card front end
// assumes: the bench calls one task at a time; the clock idles low
`timescale 1ns/100ps
`default_nettype none
module cbms_host_model (
  // link pins toward the card
  output logic link_clk_o,
  output logic cs_n_o,
  output logic din_o
);
  // no upper data line drivers exist here, so those lines always float
  initial begin
    link_clk_o = 1'b0;
    cs_n_o     = 1'b1;
    din_o      = 1'b0;
  end

  // wake-up clocks with select high; outside this and shift the clock stands
  task automatic wake();
    repeat (74) begin
      #80 link_clk_o = 1'b1;
      #80 link_clk_o = 1'b0;
    end
  endtask : wake

  // release flips data so a stale bit is never mistaken for a driven one
  task automatic select(input logic cs_n);
    cs_n_o = cs_n;
    if (cs_n) begin
      din_o = ~din_o;
      #200;
    end
  endtask : select

  // n bits msb first; select stays low for the whole frame
  task automatic shift(input logic [7:0] b, input int n);
    cs_n_o = 1'b0;
    #7;
    for (int i = 7; i > 7 - n; i--) begin
      din_o = b[i];
      #80 link_clk_o = 1'b1;
      #80 link_clk_o = 1'b0;
    end
  endtask : shift
endmodule : cbms_host_model
`default_nettype wire

// File: tb/tb_card_bus_mode_select_front_end.sv
// tb_card_bus_mode_select_front_end: self-checking bench of the front end
// assumes: cbms_pkg, the design files and cbms_host_model compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_card_bus_mode_select_front_end;
  import cbms_pkg::*;
  typedef struct {
    logic [5:0] idx; logic app; logic [31:0] arg;
    logic ini; logic acc; logic w4;
  } cbms_row_type;
  logic          ref_clk = 1'b0;
  logic          resetn;
  logic          link_clk, cs_n, din, a;
  logic          init_done = 1'b0;
  logic          prog = 1'b0;
  logic [15:0]   own_addr = 16'h1234;
  logic [3:0]    ndat = 4'h5;
  logic          nen = 1'b1;
  logic          sdo = 1'b1;
  cbms_cmd_type  cmd = '0;
  cbms_pads_type pads;
  cbms_mode_type mode;
  logic          acc, w4, fa, rxv, hold;
  logic [7:0]    rxb;
  logic [7:0]    got_q[$];
  logic [7:0]    exp_b[3] = '{8'ha5, 8'h3c, 8'hc3};
  int            failures = 0;
  int            check_count = 0;
  // native command rows: inputs, then accept and width expected
  cbms_row_type  rows[5] = '{
    '{CBMS_CMD_GO_IDLE, 1'b0, 32'h0, 1'b0, 1'b0, 1'b0},
    '{CBMS_CMD_DETECT_PULL, 1'b1, 32'h0, 1'b0, 1'b1, 1'b0},
    '{CBMS_CMD_SELECT, 1'b0, 32'h5678_0000, 1'b1, 1'b0, 1'b0},
    '{CBMS_CMD_SELECT, 1'b0, 32'h1234_0000, 1'b1, 1'b1, 1'b0},
    '{CBMS_CMD_BUS_WIDTH, 1'b1, 32'h1234_0002, 1'b1, 1'b1, 1'b1}};

  always #10 ref_clk = ~ref_clk;

  cbms_host_model u_cbms_host_model (
    .link_clk_o (link_clk),
    .cs_n_o     (cs_n),
    .din_o      (din)
  );

  cbms_front_end u_cbms_front_end (
    .ref_clk_i               (ref_clk),
    .resetn_i                (resetn),
    .link_clk_i              (link_clk),
    .detect_or_data3_line_i  (cs_n),
    .host_to_card_serial_i   (din),
    .cmd_i                   (cmd),
    .init_done_i             (init_done),
    .own_addr_i              (own_addr),
    .programming_i           (prog),
    .native_dat_i            (ndat),
    .native_dat_en_i         (nen),
    .card_to_host_serial_d_i (sdo),
    .pads_o                  (pads),
    .mode_o                  (mode),
    .cmd_accept_o            (acc),
    .width_four_o            (w4),
    .frame_active_o          (fa),
    .rx_byte_o               (rxb),
    .rx_byte_valid_o         (rxv),
    .program_hold_o          (hold)
  );

  // collect every received byte; the pulse lasts one cycle only, so look
  // mid-cycle where it has settled
  always @(negedge ref_clk) begin
    if (rxv === 1'b1) got_q.push_back(rxb);
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // command valid for one edge; accept sampled in the following cycle
  task automatic issue(input logic [5:0] i, input logic p,
                       input logic [31:0] g, output logic r);
    cmd = '{1'b1, i, p, g};
    @(negedge ref_clk);
    r = acc;
    cmd.valid = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask : issue

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    repeat (20) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (3) @(negedge ref_clk);
    foreach (rows[i]) begin
      init_done = rows[i].ini;
      issue(rows[i].idx, rows[i].app, rows[i].arg, a);
      chk(a, rows[i].acc);
      chk(w4, rows[i].w4);
      chk(pads.dat_oe, rows[i].w4 ? 4'hf : 4'h1);
    end
    chk(mode, CBMS_MODE_NATIVE);
    chk(pads.pull_en, 1'b0);
    // line drive follows the enable; pad data follows the inputs
    chk(pads.dat_out, 8'h05);
    ndat = 4'ha;
    nen  = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(pads.dat_out, 8'h0a);
    chk(pads.dat_oe, 8'h00);
    nen = 1'b1;
    // a new own address moves which commands are taken
    own_addr = 16'h5678;
    issue(CBMS_CMD_SELECT, 1'b0, 32'h5678_0000, a);
    chk(a, 1'b1);
    // a later reset command with select low must not switch protocol
    u_cbms_host_model.select(1'b0);
    repeat (3) @(negedge ref_clk);
    issue(CBMS_CMD_GO_IDLE, 1'b0, 32'h0, a);
    chk(mode, CBMS_MODE_NATIVE);
    // power cycle, then pick serial mode
    u_cbms_host_model.select(1'b1);
    resetn = 1'b0;
    init_done = 1'b0;
    repeat (20) @(negedge ref_clk);
    chk(pads.pull_en, 1'b1);
    chk(mode, CBMS_MODE_UNSET);
    chk(pads.dat_oe, 4'h0);
    resetn = 1'b1;
    u_cbms_host_model.wake();
    u_cbms_host_model.select(1'b0);
    repeat (3) @(negedge ref_clk);
    issue(CBMS_CMD_GO_IDLE, 1'b0, 32'h0, a);
    chk(mode, CBMS_MODE_SERIAL);
    chk(pads.dat_oe, 4'h1);
    chk(fa, 1'b1);
    chk(pads.dat_out, 8'h01);
    sdo = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(pads.dat_out, 8'h00);
    issue(6'h02, 1'b0, 32'h0, a);
    chk(a, 1'b0);
    issue(CBMS_CMD_SELECT, 1'b0, 32'h5678_0000, a);
    chk(a, 1'b1);
    // two bytes in one frame, a torn frame, then a fresh byte
    u_cbms_host_model.shift(8'ha5, 8);
    u_cbms_host_model.shift(8'h3c, 8);
    u_cbms_host_model.select(1'b1);
    u_cbms_host_model.shift(8'hf0, 4);
    u_cbms_host_model.select(1'b1);
    u_cbms_host_model.shift(8'hc3, 8);
    u_cbms_host_model.select(1'b1);
    @(negedge ref_clk);
    prog = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk(got_q.size(), 8'h3);
    foreach (exp_b[i]) begin
      if (i < got_q.size()) chk(got_q[i], exp_b[i]);
    end
    chk(hold, 1'b1);
    issue(CBMS_CMD_SELECT, 1'b0, 32'h5678_0000, a);
    chk(a, 1'b0);
    chk(pads.dat_oe, 4'h0);
    report_and_stop();
  end

  // watchdog well beyond the expected run of about 960 cycles
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
endmodule : tb_card_bus_mode_select_front_end
`default_nettype wire
